//--- core/dcsri_pkg.sv
// constants and types shared by the dual-channel host signalling block
package dcsri_pkg;
    localparam int DCSRI_DW         = 8;
    localparam int DCSRI_FIFO_DEPTH = 16;
    localparam int DCSRI_LVL_W      = 5;
    localparam int DCSRI_CHANNELS   = 2;

    // register offsets on the host address lines
    localparam logic [2:0] DCSRI_OFS_DATA  = 3'h0;
    localparam logic [2:0] DCSRI_OFS_IRQEN = 3'h1;
    localparam logic [2:0] DCSRI_OFS_FIFO  = 3'h2;
    localparam logic [2:0] DCSRI_OFS_LINE  = 3'h3;
    localparam logic [2:0] DCSRI_OFS_MODEM = 3'h4;
    localparam logic [2:0] DCSRI_OFS_LSTAT = 3'h5;
    localparam logic [2:0] DCSRI_OFS_FEAT  = 3'h6;
    localparam logic [2:0] DCSRI_OFS_SCRAT = 3'h7;

    // field positions
    localparam int DCSRI_FCTL_EN    = 0;
    localparam int DCSRI_FCTL_RXCLR = 1;
    localparam int DCSRI_FCTL_TXCLR = 2;
    localparam int DCSRI_FCTL_BLK   = 3;
    localparam int DCSRI_LINE_DLAB  = 7;
    localparam int DCSRI_FEAT_RS485 = 3;
    localparam int DCSRI_IEN_RX     = 0;
    localparam int DCSRI_IEN_TX     = 1;
    localparam int DCSRI_MODEM_RTS  = 1;

    // values
    localparam logic [7:0]  DCSRI_FCTL_KEEP = 8'hf9;
    localparam logic [5:0]  DCSRI_ID_NONE   = 6'h01;
    localparam logic [5:0]  DCSRI_ID_TX     = 6'h02;
    localparam logic [5:0]  DCSRI_ID_RX     = 6'h04;
    localparam logic [5:0]  DCSRI_ID_TMO    = 6'h0c;
    localparam logic [14:0] DCSRI_PINS_IDLE = 15'h5800;

    typedef struct packed {
        logic [7:0] irq_en;
        logic [7:0] fifo_ctl;
        logic [7:0] line_ctl;
        logic [7:0] modem_ctl;
        logic [7:0] scratch;
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic [7:0] div_frac;
        logic [7:0] feat_ctl;
        logic [3:0] tx_trig;
        logic [3:0] rx_trig;
    } dcsri_regs_t;

    localparam dcsri_regs_t DCSRI_REGS_RST = 80'h0000_0000_0001_0000_0088;

    typedef struct packed {
        logic       cs_n;
        logic       pick;
        logic       rd_n;
        logic       wr_n;
        logic [2:0] addr;
        logic [7:0] data;
    } dcsri_pins_t;
endpackage

//--- core/dcsri_top.sv
// dual-channel host bus decode, ready pins, interrupt pins and data fifos
`timescale 1ns/1ps
`default_nettype none

module dcsri_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int LW    = 5
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             ce,
    input  wire logic             flush,
    input  wire logic             one_deep,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready,
    output logic [LW-1:0]         level
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    rd_ptr;
    logic [PW-1:0]    wr_ptr;

    wire             push       = in_valid & in_ready;
    wire             pop        = out_valid & out_ready;
    wire [PW-1:0]    next_rd    = pop ? rd_ptr + 1'b1 : rd_ptr;
    wire [LW-1:0]    next_level = level + LW'(push) - LW'(pop);
    wire [LW-1:0]    cap        = one_deep ? LW'(1) : LW'(DEPTH);
    wire             bypass     = push && (wr_ptr == next_rd);
    wire [WIDTH-1:0] next_out   = bypass ? in_data : mem[next_rd];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_ptr    <= '0;
            wr_ptr    <= '0;
            level     <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
            in_ready  <= 1'b1;
        end else if (ce && flush) begin
            rd_ptr    <= '0;
            wr_ptr    <= '0;
            level     <= '0;
            out_valid <= 1'b0;
            in_ready  <= 1'b1;
        end else if (ce) begin
            rd_ptr    <= next_rd;
            wr_ptr    <= push ? wr_ptr + 1'b1 : wr_ptr;
            level     <= next_level;
            out_valid <= next_level != '0;
            out_data  <= next_out;
            in_ready  <= next_level < cap;
        end
    end

    always_ff @(posedge clk) begin
        if (ce && push && !flush) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

module dcsri_top
    import dcsri_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            reset_n,
    input  wire logic            ce,
    input  wire logic            cs_n,
    input  wire logic            channel_pick,
    input  wire logic            read_strobe_n,
    input  wire logic            write_strobe_n,
    input  wire logic [2:0]      addr,
    input  wire logic [7:0]      data_in,
    output logic [7:0]           data_out,
    output logic                 data_oe,
    output logic [1:0][7:0]      tx_data,
    output logic [1:0]           tx_valid,
    input  wire logic [1:0]      tx_ready,
    input  wire logic [1:0]      tx_shift_busy,
    input  wire logic [1:0][7:0] rx_data,
    input  wire logic [1:0]      rx_valid,
    output logic [1:0]           rx_ready,
    input  wire logic [1:0]      rx_timeout,
    output logic [1:0]           rx_block_ready_n,
    output logic [1:0]           tx_space_ready_n,
    output logic [1:0]           line_dir_n,
    output logic                 irq_out_first,
    output logic                 irq_out_second
);
    function automatic logic reg_hit(input dcsri_pins_t p, input logic c, input logic [2:0] ofs);
        reg_hit = !p.cs_n && (p.pick == !c) && (p.addr == ofs);
    endfunction

    dcsri_pins_t pins_raw;
    dcsri_pins_t pins_meta;
    dcsri_pins_t pins_sync;
    dcsri_pins_t pins_prev;

    assign pins_raw = {cs_n, channel_pick, read_strobe_n, write_strobe_n, addr, data_in};

    // host pins run through three flops; bus logic uses clk only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pins_meta <= DCSRI_PINS_IDLE;
            pins_sync <= DCSRI_PINS_IDLE;
            pins_prev <= DCSRI_PINS_IDLE;
        end else if (ce) begin
            pins_meta <= pins_raw;
            pins_sync <= pins_meta;
            pins_prev <= pins_sync;
        end
    end

    // read acts at strobe fall, write at strobe rise
    wire       read_on = !pins_sync.cs_n && !pins_sync.rd_n;
    wire       rd_go   = read_on && pins_prev.rd_n;
    wire       wr_go   = !pins_prev.cs_n && !pins_prev.wr_n && pins_sync.wr_n;
    wire       rd_ch   = !pins_sync.pick;
    wire [2:0] ra      = pins_sync.addr;
    wire [2:0] wa      = pins_prev.addr;
    wire [7:0] wd      = pins_prev.data;

    logic [7:0] rd_val [2];
    logic [1:0] next_rx_block_ready_n_n;
    logic [1:0] next_tx_space_ready_n_n;
    logic [1:0] next_irq;
    logic [1:0] next_dir_n;
    logic [1:0] irq_q;

    for (genvar g = 0; g < DCSRI_CHANNELS; g++) begin : gen_ch
        dcsri_regs_t            r;
        logic                   ovr;
        logic                   tmo;
        logic                   tx_room;
        logic [7:0]             rx_head;
        logic                   rx_have;
        logic [DCSRI_LVL_W-1:0] tx_lvl;
        logic [DCSRI_LVL_W-1:0] rx_lvl;
        logic [7:0]             view [8];

        wire w       = wr_go && reg_hit(pins_prev, 1'(g), wa);
        wire rd      = rd_go && reg_hit(pins_sync, 1'(g), ra);
        wire dlab    = r.line_ctl[DCSRI_LINE_DLAB];
        wire fen     = r.fifo_ctl[DCSRI_FCTL_EN];
        wire blk     = fen && r.fifo_ctl[DCSRI_FCTL_BLK];
        wire a485    = r.feat_ctl[DCSRI_FEAT_RS485];
        wire tx_push = w && wa == DCSRI_OFS_DATA && !dlab;
        wire rx_pop  = rd && ra == DCSRI_OFS_DATA && !dlab;
        wire fw      = w && wa == DCSRI_OFS_FIFO && !dlab;
        wire en_chg  = wd[DCSRI_FCTL_EN] != fen;
        wire flush_r = fw && (wd[DCSRI_FCTL_RXCLR] || en_chg);
        wire flush_t = fw && (wd[DCSRI_FCTL_TXCLR] || en_chg);
        wire tx_idle = tx_lvl == '0;
        wire tx_all  = tx_idle && !tx_shift_busy[g];
        wire tx_low  = tx_lvl < {1'b0, r.tx_trig};
        wire rx_hit  = rx_lvl >= {1'b0, r.rx_trig};
        wire rx_any  = rx_lvl != '0;
        wire lst_rd  = rd && ra == DCSRI_OFS_LSTAT;

        wire tx_cond = a485 ? (tx_all || (fen && tx_low)) : (fen ? (tx_low || tx_idle) : tx_idle);
        wire rx_cond = fen ? rx_hit : rx_any;
        wire ien_rx  = r.irq_en[DCSRI_IEN_RX];
        wire ien_tx  = r.irq_en[DCSRI_IEN_TX];

        wire [5:0] irq_id = (ien_rx && rx_cond) ? DCSRI_ID_RX :
                            (ien_rx && tmo) ? DCSRI_ID_TMO :
                            (ien_tx && tx_cond) ? DCSRI_ID_TX : DCSRI_ID_NONE;
        wire [7:0] lstat = {1'b0, tx_all, tx_room, 3'h0, ovr, rx_any};

        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                r <= DCSRI_REGS_RST;
            end else if (ce && w) begin
                case (wa)
                    DCSRI_OFS_DATA: begin
                        if (dlab) r.div_lo <= wd;
                    end
                    DCSRI_OFS_IRQEN: begin
                        if (dlab) r.div_hi <= wd;
                        else r.irq_en <= wd;
                    end
                    DCSRI_OFS_FIFO: begin
                        if (dlab) r.div_frac <= {4'h0, wd[3:0]};
                        else r.fifo_ctl <= wd & DCSRI_FCTL_KEEP;
                    end
                    DCSRI_OFS_LINE:  r.line_ctl <= wd;
                    DCSRI_OFS_MODEM: r.modem_ctl <= wd;
                    DCSRI_OFS_LSTAT: {r.tx_trig, r.rx_trig} <= wd;
                    DCSRI_OFS_FEAT:  r.feat_ctl <= wd;
                    DCSRI_OFS_SCRAT: r.scratch <= wd;
                    default: ;
                endcase
            end
        end

        // sticky overrun and time-out; a new event beats the clear
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                ovr <= 1'b0;
                tmo <= 1'b0;
            end else if (ce) begin
                ovr <= (rx_valid[g] && !rx_ready[g]) || (ovr && !lst_rd);
                tmo <= (fen && rx_timeout[g]) || (tmo && !rx_pop && rx_any);
            end
        end

        dcsri_fifo #(
            .WIDTH (DCSRI_DW),
            .DEPTH (DCSRI_FIFO_DEPTH),
            .LW    (DCSRI_LVL_W)
        ) u_tx_fifo (
            .clk       (clk),
            .reset_n   (reset_n),
            .ce        (ce),
            .flush     (flush_t),
            .one_deep  (!fen),
            .in_valid  (tx_push),
            .in_data   (wd),
            .in_ready  (tx_room),
            .out_valid (tx_valid[g]),
            .out_data  (tx_data[g]),
            .out_ready (tx_ready[g]),
            .level     (tx_lvl)
        );

        dcsri_fifo #(
            .WIDTH (DCSRI_DW),
            .DEPTH (DCSRI_FIFO_DEPTH),
            .LW    (DCSRI_LVL_W)
        ) u_rx_fifo (
            .clk       (clk),
            .reset_n   (reset_n),
            .ce        (ce),
            .flush     (flush_r),
            .one_deep  (!fen),
            .in_valid  (rx_valid[g]),
            .in_data   (rx_data[g]),
            .in_ready  (rx_ready[g]),
            .out_valid (rx_have),
            .out_data  (rx_head),
            .out_ready (rx_pop),
            .level     (rx_lvl)
        );

        assign view[0] = dlab ? r.div_lo : (rx_have ? rx_head : 8'h00);
        assign view[1] = dlab ? r.div_hi : r.irq_en;
        assign view[2] = dlab ? r.div_frac : {fen, fen, irq_id};
        assign view[3] = r.line_ctl;
        assign view[4] = r.modem_ctl;
        assign view[5] = lstat;
        assign view[6] = r.feat_ctl;
        assign view[7] = r.scratch;
        assign rd_val[g] = view[ra];

        assign next_rx_block_ready_n_n[g] = !blk ? !rx_any :
                                 !rx_any ? 1'b1 :
                                 (rx_hit || rx_timeout[g]) ? 1'b0 : rx_block_ready_n[g];
        assign next_tx_space_ready_n_n[g] = blk ? !tx_room : !tx_idle;
        assign next_irq[g]     = (ien_rx && (rx_cond || tmo)) || (ien_tx && tx_cond);
        assign next_dir_n[g]   = a485 ? tx_all : !r.modem_ctl[DCSRI_MODEM_RTS];
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            data_out         <= 8'h00;
            data_oe          <= 1'b0;
            rx_block_ready_n <= 2'h3;
            tx_space_ready_n <= 2'h0;
            line_dir_n       <= 2'h3;
            irq_q            <= 2'h0;
        end else if (ce) begin
            data_out         <= rd_go ? rd_val[rd_ch] : data_out;
            data_oe          <= read_on;
            rx_block_ready_n <= next_rx_block_ready_n_n;
            tx_space_ready_n <= next_tx_space_ready_n_n;
            line_dir_n       <= next_dir_n;
            irq_q            <= next_irq;
        end
    end

    assign irq_out_first  = irq_q[0];
    assign irq_out_second = irq_q[1];
endmodule

`default_nettype wire

//--- tb/dcsri_top_properties.sv
// port assertions for the dual-channel host signalling block
`timescale 1ns/1ps
`default_nettype none
module dcsri_checker (
    input wire logic            clk,
    input wire logic            reset_n,
    input wire logic            cs_n,
    input wire logic            read_strobe_n,
    input wire logic [7:0]      data_out,
    input wire logic            data_oe,
    input wire logic [1:0][7:0] tx_data,
    input wire logic [1:0]      tx_valid,
    input wire logic [1:0]      tx_ready,
    input wire logic [1:0]      rx_valid,
    input wire logic [1:0]      rx_ready,
    input wire logic [1:0]      rx_timeout,
    input wire logic [1:0]      rx_block_ready_n,
    input wire logic [1:0]      tx_space_ready_n,
    input wire logic [1:0]      line_dir_n,
    input wire logic            irq_out_first,
    input wire logic            irq_out_second
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_desel; cs_n[*5] |-> !data_oe; endproperty
    a_desel: assert property (p_desel) else $error("read drive while deselected");
    property p_oe_rise; $rose(data_oe) |-> !cs_n && !read_strobe_n; endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("read drive without strobe");
    property p_oe_fall; $fell(data_oe) |-> cs_n || read_strobe_n; endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("read drive dropped early");
    property p_hold; data_oe && $past(data_oe) |-> $stable(data_out); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_rst;
        $rose(reset_n) |-> rx_block_ready_n == 2'b11 && tx_space_ready_n == 2'b00
            && line_dir_n == 2'b11 && !irq_out_first && !irq_out_second;
    endproperty
    a_rst: assert property (p_rst) else $error("pins wrong after reset");
    property p_quiet;
        (cs_n && !rx_valid[0] && !rx_timeout[0] && !tx_ready[0])[*8] |=>
            $stable(rx_block_ready_n[0]) && $stable(tx_space_ready_n[0]) && $stable(tx_valid[0]);
    endproperty
    a_quiet: assert property (p_quiet) else $error("pins moved while idle");
    property p_txhold; tx_valid[0] && !tx_ready[0] |=> tx_valid[0] && $stable(tx_data[0]); endproperty
    a_txhold: assert property (p_txhold) else $error("tx head lost");
    property p_rxfull; (!rx_ready[1])[*3] |-> !rx_block_ready_n[1]; endproperty
    a_rxfull: assert property (p_rxfull) else $error("rx ready pin high with rx full");
endmodule
bind dcsri_top dcsri_checker dcsri_checker_inst (.clk, .reset_n, .cs_n, .read_strobe_n,
    .data_out, .data_oe, .tx_data, .tx_valid, .tx_ready, .rx_valid, .rx_ready, .rx_timeout,
    .rx_block_ready_n, .tx_space_ready_n, .line_dir_n, .irq_out_first, .irq_out_second);
`default_nettype wire

//--- tb/dcsri_host.sv
// host cpu model driving the asynchronous select and strobe pins
`timescale 1ns/1ps
`default_nettype none
module dcsri_host (
    input  wire logic       clk,
    input  wire logic [7:0] data_out,
    output logic            cs_n,
    output logic            channel_pick,
    output logic            read_strobe_n,
    output logic            write_strobe_n,
    output logic [2:0]      addr,
    output logic [7:0]      data_in
);
    initial begin
        cs_n = 1'b1;
        channel_pick = 1'b0;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        addr = 3'h0;
        data_in = 8'h00;
    end
    // pk[1] high keeps chip select off, pk[0] picks the channel
    task automatic acc(input logic wr, input logic [1:0] pk, input logic [2:0] a,
                       input logic [7:0] d, output logic [7:0] r);
        @(posedge clk);
        cs_n <= pk[1];
        channel_pick <= pk[0];
        addr <= a;
        data_in <= d;
        repeat (2) @(posedge clk);
        read_strobe_n <= wr;
        write_strobe_n <= !wr;
        repeat (6) @(posedge clk);
        r = data_out;
        read_strobe_n <= 1'b1;
        write_strobe_n <= 1'b1;
        repeat (6) @(posedge clk);
        cs_n <= 1'b1;
        addr <= ~a;
        data_in <= ~d;
        repeat (4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

//--- tb/dcsri_top_tb.sv
// self-checking bench for the dual-channel host signalling block
`timescale 1ns/1ps
`default_nettype none
module dcsri_top_tb;
    typedef struct packed {
        logic [1:0] pk;
        logic [2:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } dcsri_row_t;
    localparam dcsri_row_t ROWS [5] = '{
        '{2'b01, 3'h7, 8'h5a, 8'h5a}, '{2'b00, 3'h7, 8'hc3, 8'hc3},
        '{2'b01, 3'h3, 8'h1b, 8'h1b}, '{2'b00, 3'h3, 8'h03, 8'h03},
        '{2'b10, 3'h7, 8'hff, 8'h03}};
    logic                 clk = 1'b0;
    logic                 reset_n = 1'b0;
    logic                 ce = 1'b1;
    logic [1:0]           tx_ready = 2'b00;
    logic [1:0]           tx_shift_busy = 2'b00;
    logic [1:0]           rx_valid = 2'b00;
    logic [1:0]           rx_timeout = 2'b00;
    logic [1:0][7:0]      rx_data = '0;
    logic [7:0]           q;
    int                   num_errors = 0;
    int                   compares = 0;
    int                   n = 0;
    wire logic            cs_n, channel_pick, read_strobe_n, write_strobe_n, data_oe;
    wire logic            irq_out_first, irq_out_second;
    wire logic [2:0]      addr;
    wire logic [7:0]      data_in, data_out;
    wire logic [1:0]      tx_valid, rx_ready, rx_block_ready_n, tx_space_ready_n, line_dir_n;
    wire logic [1:0][7:0] tx_data;
    wire logic [7:0]      pins = {rx_block_ready_n, tx_space_ready_n, line_dir_n,
                                  irq_out_first, irq_out_second};
    initial begin
        forever #2.5 clk = ~clk;
    end
    dcsri_top dcsri_top_inst (.clk, .reset_n, .ce, .cs_n, .channel_pick, .read_strobe_n,
        .write_strobe_n, .addr, .data_in, .data_out, .data_oe, .tx_data, .tx_valid,
        .tx_ready, .tx_shift_busy, .rx_data, .rx_valid, .rx_ready, .rx_timeout,
        .rx_block_ready_n, .tx_space_ready_n, .line_dir_n, .irq_out_first, .irq_out_second);
    dcsri_host dcsri_host_inst (.clk, .data_out, .cs_n, .channel_pick, .read_strobe_n,
        .write_strobe_n, .addr, .data_in);
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] pk, input logic [2:0] a, input logic [7:0] d);
        dcsri_host_inst.acc(1'b1, pk, a, d, q);
    endtask
    task automatic rd(input logic [1:0] pk, input logic [2:0] a, input logic [7:0] m,
                      input logic [7:0] e);
        dcsri_host_inst.acc(1'b0, pk, a, 8'h00, q);
        chk8(q & m, e);
    endtask
    task automatic push(input int ch, input logic [7:0] d);
        @(posedge clk);
        rx_data[ch] <= d;
        rx_valid[ch] <= 1'b1;
        @(posedge clk);
        rx_data[ch] <= ~d;
        rx_valid[ch] <= 1'b0;
    endtask
    task automatic final_report;
        if (num_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk8(pins, 8'hcc);
        for (int i = 0; i < 5; i++) wr(ROWS[i].pk, ROWS[i].a, ROWS[i].d);
        for (int i = 0; i < 5; i++) rd(ROWS[i].pk, ROWS[i].a, 8'hff, ROWS[i].e);
        rd(2'b01, 3'h5, 8'h60, 8'h60);
        wr(2'b01, 3'h1, 8'h02);
        chk8(pins, 8'hce);
        wr(2'b01, 3'h0, 8'h3c);
        chk8(pins, 8'hdc);
        chk8(tx_data[0], 8'h3c);
        rd(2'b01, 3'h5, 8'h60, 8'h00);
        tx_ready[0] <= 1'b1;
        @(posedge clk);
        tx_ready[0] <= 1'b0;
        repeat (3) @(posedge clk);
        chk8(pins, 8'hce);
        wr(2'b01, 3'h6, 8'h08);
        chk8(pins, 8'hce);
        tx_shift_busy[0] <= 1'b1;
        repeat (3) @(posedge clk);
        chk8(pins, 8'hc8);
        tx_shift_busy[0] <= 1'b0;
        push(1, 8'h77);
        repeat (3) @(posedge clk);
        chk8(pins, 8'h4e);
        chk8({6'h00, rx_ready}, 8'h01);
        rd(2'b00, 3'h0, 8'hff, 8'h77);
        chk8(pins, 8'hce);
        wr(2'b01, 3'h2, 8'h09);
        wr(2'b01, 3'h1, 8'h01);
        for (int i = 0; i < 7; i++) push(0, 8'h10 + i[7:0]);
        repeat (3) @(posedge clk);
        chk8(pins, 8'hcc);
        push(0, 8'h17);
        repeat (3) @(posedge clk);
        chk8(pins, 8'h8e);
        for (int i = 0; i < 7; i++) rd(2'b01, 3'h0, 8'hff, 8'h10 + i[7:0]);
        chk8(pins, 8'h8c);
        rd(2'b01, 3'h0, 8'hff, 8'h17);
        chk8(pins, 8'hcc);
        push(0, 8'h99);
        rx_timeout[0] <= 1'b1;
        @(posedge clk);
        rx_timeout[0] <= 1'b0;
        repeat (3) @(posedge clk);
        chk8(pins, 8'h8e);
        rd(2'b01, 3'h0, 8'hff, 8'h99);
        chk8(pins, 8'hcc);
        for (int i = 0; i < 17; i++) begin
            wr(2'b01, 3'h0, 8'h40 + i[7:0]);
            if (i == 14) chk8(pins, 8'hc8);
            if (i == 15) chk8(pins, 8'hd8);
        end
        chk8(pins, 8'hd8);
        for (int k = 0; k < 80; k++) begin
            @(posedge clk);
            if ((tx_valid[0] & tx_ready[0]) === 1'b1) begin
                chk8(tx_data[0], 8'h40 + n[7:0]);
                n++;
            end
            tx_ready[0] <= k[1];
        end
        @(posedge clk);
        tx_ready[0] <= 1'b0;
        repeat (3) @(posedge clk);
        chk8(n[7:0], 8'h10);
        chk8(pins, 8'hcc);
        wr(2'b00, 3'h1, 8'h02);
        chk8(pins, 8'hcd);
        // clock enable low must freeze the rx path
        ce <= 1'b0;
        push(1, 8'h55);
        repeat (3) @(posedge clk);
        chk8(pins, 8'hcd);
        chk8({6'h00, rx_ready}, 8'h03);
        ce <= 1'b1;
        rd(2'b00, 3'h0, 8'hff, 8'h00);
        // reset in mid-run returns pins to idle and rs485 off
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk8(pins, 8'hcc);
        final_report;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        final_report;
    end
endmodule
`default_nettype wire
